/* File: logic/crd_decoder.sv */
/*
  Command byte decoder of a two-wire light sensor slave: keeps the command
  pointer, steers register accesses, issues special functions and inserts the
  SMBus byte count of the fixed four-byte block read.
  Assumes a byte-level bus front end that reports start, stop, received bytes
  and read requests one per cycle, and a register file that returns the byte
  at reg_addr_out combinationally on reg_rdata_in.
*/
// Functional notes
// (R01) Eight-bit command pointer, zero after reset.
// (R02) Host sets bit 7 on every command byte.
// (R03) First written byte with bit 7 set is a command byte.
// (R04) Type 00 selects byte transfers, 01 word transfers.
// (R05) Type 10 selects block transfers on either bus flavour.
// (R06) Type 11 makes the low field a special function code.
// (R07) Low five bits select the target register otherwise.
// (R08) Code 00001 pulses interrupt clear once, no stored state.
// (R09) Code 00010 stops manual integration when setting is zero.
// (R10) Code 00011 starts manual integration when setting is zero.
// (R11) Measured manual integration length is readable afterwards.
// (R12) Host never issues code 00000 or x11xx.
// (R13) I2C block transfers continue until the stop.
// (R14) SMBus block transfers carry a byte count, I2C ones none; the code skips it on writes but supplies one on reads only for D3h.
// (R15) Host byte count ignored; bytes actually moved are counted.
// (R16) One block read returns registers 14h to 17h.
// (R17) Host uses block type and command D3h for it.
// (R18) With D3h the device supplies byte count 4 first.
// (R19) Host never writes register 13h.
// (R20) Host clears interrupts only by send byte.
// (R21) Receive byte returns the register the pointer selects.
// (R22) Pointer address and type persist until the next command.
// (R23) Special codes act on acceptance and keep the pointer.
`timescale 1ns/1ps
`default_nettype none
`include "crd_regs.svh"

module crd_decoder
  import crd_pkg::*;
#(
  parameter int TICK_CYC = `CRD_TIMER_TICK_CYC,
  parameter int TIMER_W  = 16
) (
  // Clock and reset
  input  wire logic               clk_sys_in,
  input  wire logic               rst_n_in,
  // Byte-level bus events
  input  wire crd_bus_evt_t       bus_evt_in,
  input  wire logic               smbus_mode_in,
  // Register file
  input  wire logic [7:0]         integration_length_setting_in,
  input  wire logic [7:0]         reg_rdata_in,
  output logic [4:0]              reg_addr_out,
  output logic                    reg_wr_out,
  output logic [7:0]              reg_wdata_out,
  // Read answer
  output logic [7:0]              rd_data_out,
  output logic                    rd_valid_out,
  // Status
  output logic [7:0]              command_pointer_out,
  output logic [7:0]              xfer_count_out,
  // Special functions
  output logic                    int_clear_out,
  output logic                    manual_start_out,
  output logic                    manual_stop_out,
  output logic                    manual_busy_out,
  output logic [TIMER_W-1:0]      manual_timer_out
);

  // --------------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------------
  crd_phase_t phase;
  crd_phase_t next_phase;
  logic       cnt_pend;
  logic       next_cnt_pend;
  logic [7:0] next_ptr;
  logic [4:0] next_acc;
  logic       next_wr;
  logic [7:0] next_wdata;
  logic [7:0] next_rdata;
  logic       next_rvalid;
  logic [7:0] next_cnt;
  logic       next_ic;
  logic       next_mstart;
  logic       next_mstop;

  crd_cmd_t   in_cmd;
  crd_cmd_t   cur_cmd;
  logic       advance;
  logic       manual_ok;
  logic       cmd_evt;

  assign in_cmd    = crd_cmd_t'(bus_evt_in.wr_byte);
  assign cur_cmd   = crd_cmd_t'(command_pointer_out);
  assign manual_ok = (integration_length_setting_in == `CRD_MANUAL_SETTING);
  // Word and block transfers walk the address, byte transfers stay put
  assign advance   = (cur_cmd.xfer != CRD_XF_BYTE); // R04 R05
  assign cmd_evt   = !bus_evt_in.start && bus_evt_in.wr_valid
                     && (phase == CRD_PH_FIRST) && in_cmd.flag;

  always_comb begin
    next_phase    = phase;
    next_cnt_pend = cnt_pend;
    next_ptr      = command_pointer_out;
    next_acc      = reg_addr_out;
    next_wr       = 1'b0;
    next_wdata    = reg_wdata_out;
    next_rdata    = rd_data_out;
    next_rvalid   = 1'b0;
    next_cnt      = xfer_count_out;
    next_ic       = 1'b0;
    next_mstart   = 1'b0;
    next_mstop    = 1'b0;
    if (bus_evt_in.stop) begin
      next_phase    = CRD_PH_IDLE;
      next_cnt_pend = 1'b0;
    end
    if (bus_evt_in.start) begin
      // Every frame, including a repeated start, resumes at the pointer
      next_phase    = CRD_PH_FIRST;
      next_acc      = cur_cmd.addr; // R21 R22
      next_cnt      = 8'h00;
      next_cnt_pend = smbus_mode_in && (cur_cmd.xfer == CRD_XF_BLOCK)
                      && (cur_cmd.addr == `CRD_ADDR_COUNT_REG); // R16 R18
    end else if (cmd_evt) begin // R03
      next_phase = CRD_PH_DATA;
      if (in_cmd.xfer == CRD_XF_SPECIAL) begin // R06 R23
        unique case (in_cmd.addr)
          `CRD_SF_INT_CLEAR: next_ic = 1'b1; // R08
          `CRD_SF_MAN_STOP:  next_mstop = manual_ok; // R09
          `CRD_SF_MAN_START: next_mstart = manual_ok; // R10
          default: ;
        endcase
      end else begin
        next_ptr = bus_evt_in.wr_byte; // R07 R22
        next_acc = in_cmd.addr; // R07
        // SMBus block writes carry a count byte that is skipped
        if (smbus_mode_in && (in_cmd.xfer == CRD_XF_BLOCK)) begin
          next_phase = CRD_PH_COUNT; // R14 R05
        end
      end
    end else if (bus_evt_in.wr_valid && (phase == CRD_PH_COUNT)) begin
      next_phase = CRD_PH_DATA; // R15 R14
    end else if (bus_evt_in.wr_valid && (phase != CRD_PH_IDLE)) begin
      next_phase = CRD_PH_DATA;
      next_wr    = 1'b1;
      next_wdata = bus_evt_in.wr_byte;
      next_cnt   = xfer_count_out + 8'h01; // R15
      if (advance) begin
        next_acc = reg_addr_out + 5'h01;
      end
    end else if (bus_evt_in.rd_req && (phase != CRD_PH_IDLE)) begin
      next_phase  = CRD_PH_DATA;
      next_rvalid = 1'b1; // R13
      if (cnt_pend) begin
        next_rdata    = `CRD_BLOCK_COUNT; // R18
        next_acc      = `CRD_ADDR_DATA_FIRST; // R16
        next_cnt_pend = 1'b0;
      end else begin
        next_rdata = reg_rdata_in; // R21
        next_cnt   = xfer_count_out + 8'h01; // R15
        if (advance) begin
          next_acc = reg_addr_out + 5'h01;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase               <= CRD_PH_IDLE;
      cnt_pend            <= 1'b0;
      command_pointer_out <= `CRD_CMD_RESET; // R01
      reg_addr_out        <= 5'h00;
      reg_wr_out          <= 1'b0;
      reg_wdata_out       <= 8'h00;
      rd_data_out         <= 8'h00;
      rd_valid_out        <= 1'b0;
      xfer_count_out      <= 8'h00;
      int_clear_out       <= 1'b0;
      manual_start_out    <= 1'b0;
      manual_stop_out     <= 1'b0;
    end else begin
      phase               <= next_phase;
      cnt_pend            <= next_cnt_pend;
      command_pointer_out <= next_ptr;
      reg_addr_out        <= next_acc;
      reg_wr_out          <= next_wr;
      reg_wdata_out       <= next_wdata;
      rd_data_out         <= next_rdata;
      rd_valid_out        <= next_rvalid;
      xfer_count_out      <= next_cnt;
      int_clear_out       <= next_ic;
      manual_start_out    <= next_mstart;
      manual_stop_out     <= next_mstop;
    end
  end

  // --------------------------------------------------------------------------
  // Manual integration timer
  // --------------------------------------------------------------------------
  crd_man_timer #(
    .TICK_CYC (TICK_CYC),
    .W        (TIMER_W)
  ) u_timer (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .start_in   (manual_start_out),
    .stop_in    (manual_stop_out),
    .busy_out   (manual_busy_out),
    .count_out  (manual_timer_out) // R11
  );

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_special(logic [4:0] code);
    cmd_evt && (in_cmd.xfer == CRD_XF_SPECIAL) && (in_cmd.addr == code);
  endsequence

  sequence s_count_byte;
    bus_evt_in.rd_req && cnt_pend && !bus_evt_in.start && (phase != CRD_PH_IDLE);
  endsequence

  a_ptr_load_cmd: assert property ( // R07
    cmd_evt && (in_cmd.xfer != CRD_XF_SPECIAL)
    |=> (command_pointer_out == $past(bus_evt_in.wr_byte))
        && (reg_addr_out == $past(in_cmd.addr)))
    else $error("command byte not loaded into pointer");

  a_special_keeps_ptr: assert property ( // R23
    cmd_evt && (in_cmd.xfer == CRD_XF_SPECIAL) |=> $stable(command_pointer_out))
    else $error("special code altered the pointer");

  a_int_clear_once: assert property ( // R08
    s_special(`CRD_SF_INT_CLEAR) |=> int_clear_out ##1 !int_clear_out)
    else $error("interrupt clear not a single pulse");

  a_man_stop_gate: assert property ( // R09
    s_special(`CRD_SF_MAN_STOP) |=> (manual_stop_out == $past(manual_ok)))
    else $error("manual stop not gated by the setting");

  a_man_start_run: assert property ( // R10
    s_special(`CRD_SF_MAN_START) ##0 manual_ok |=> manual_start_out ##1 manual_busy_out)
    else $error("manual start did not start the timer");

  a_block_count_ins: assert property ( // R18
    s_count_byte |=> rd_valid_out && (rd_data_out == `CRD_BLOCK_COUNT)
                     && (reg_addr_out == `CRD_ADDR_DATA_FIRST))
    else $error("byte count 4 not inserted");

  a_count_skip: assert property ( // R15
    bus_evt_in.wr_valid && !bus_evt_in.start && (phase == CRD_PH_COUNT)
    |=> !reg_wr_out && $stable(xfer_count_out))
    else $error("host byte count was not ignored");

  a_frame_ptr_addr: assert property ( // R21
    bus_evt_in.start |=> (reg_addr_out == $past(cur_cmd.addr)))
    else $error("frame did not resume at the pointer");

  a_word_advance: assert property ( // R04
    (cur_cmd.xfer == CRD_XF_WORD) && bus_evt_in.wr_valid && !bus_evt_in.start
    && (phase == CRD_PH_DATA)
    |=> reg_wr_out && (reg_addr_out == $past(reg_addr_out) + 5'h01))
    else $error("word transfer did not advance");

  a_stream_read: assert property ( // R13
    bus_evt_in.rd_req && !bus_evt_in.start && (phase == CRD_PH_DATA)
    |=> rd_valid_out)
    else $error("read request in a frame got no byte");

endmodule : crd_decoder
`default_nettype wire

/* File: logic/crd_man_timer.sv */
/*
  Manual integration timer: measures the length of a manual integration in
  ticks of a divided enable. Assumes one-cycle start and stop pulses.
*/
`timescale 1ns/1ps
`default_nettype none
`include "crd_regs.svh"

module crd_man_timer
  import crd_pkg::*;
#(
  parameter int TICK_CYC = `CRD_TIMER_TICK_CYC,
  parameter int W        = 16
) (
  // Clock and reset
  input  wire logic         clk_sys_in,
  input  wire logic         rst_n_in,
  // Control
  input  wire logic         start_in,
  input  wire logic         stop_in,
  // Result
  output logic              busy_out,
  output logic [W-1:0]      count_out
);

  localparam int DW = $clog2(TICK_CYC + 1);

  logic [DW-1:0] div_cnt;
  logic [DW-1:0] next_div_cnt;
  logic          next_busy;
  logic [W-1:0]  next_count;

  always_comb begin
    next_div_cnt = div_cnt;
    next_busy    = busy_out;
    next_count   = count_out;
    if (start_in) begin
      next_busy    = 1'b1;
      next_count   = '0;
      next_div_cnt = '0;
    end else if (stop_in) begin
      next_busy = 1'b0;
    end else if (busy_out) begin
      if (div_cnt == DW'(TICK_CYC - 1)) begin
        next_div_cnt = '0;
        // Saturate rather than wrap so a long run never reads as short
        if (count_out != '1) begin
          next_count = count_out + W'(1);
        end
      end else begin
        next_div_cnt = div_cnt + DW'(1);
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_cnt   <= '0;
      busy_out  <= 1'b0;
      count_out <= '0;
    end else begin
      div_cnt   <= next_div_cnt;
      busy_out  <= next_busy;
      count_out <= next_count;
    end
  end

endmodule : crd_man_timer
`default_nettype wire

/* File: logic/crd_pkg.sv */
/*
  Types of the command byte decoder: transfer types, frame phases, the
  command byte layout and the byte-level bus event bundle.
  Assumes a byte-level two-wire front end outside this block.
*/
`default_nettype none

package crd_pkg;

  typedef enum logic [1:0] {
    CRD_XF_BYTE    = 2'b00,
    CRD_XF_WORD    = 2'b01,
    CRD_XF_BLOCK   = 2'b10,
    CRD_XF_SPECIAL = 2'b11
  } crd_xfer_t;

  typedef enum logic [1:0] {
    CRD_PH_IDLE  = 2'b00,
    CRD_PH_FIRST = 2'b01,
    CRD_PH_COUNT = 2'b10,
    CRD_PH_DATA  = 2'b11
  } crd_phase_t;

  typedef struct packed {
    logic      flag;
    crd_xfer_t xfer;
    logic [4:0] addr;
  } crd_cmd_t;

  typedef struct packed {
    logic       start;
    logic       stop;
    logic       wr_valid;
    logic [7:0] wr_byte;
    logic       rd_req;
  } crd_bus_evt_t;

endpackage : crd_pkg

`default_nettype wire

/* File: logic/crd_regs.svh */
/*
  Constants of the command byte decoder: command byte field positions, reset
  value, special function codes, fixed block read addresses and timer counts.
  Assumes a 125 MHz system clock; included by the modules that use it.
*/
`ifndef CRD_REGS_SVH
`define CRD_REGS_SVH

// ----------------------------------------------------------------------------
// Command byte
// ----------------------------------------------------------------------------
`define CRD_CMD_RESET        8'h00
`define CRD_CMD_FLAG_BIT     7
`define CRD_TYPE_MSB         6
`define CRD_TYPE_LSB         5
`define CRD_ADDR_MSB         4
`define CRD_ADDR_LSB         0

// ----------------------------------------------------------------------------
// Special function codes and fixed block read
// ----------------------------------------------------------------------------
`define CRD_SF_INT_CLEAR     5'h01
`define CRD_SF_MAN_STOP      5'h02
`define CRD_SF_MAN_START     5'h03
`define CRD_MANUAL_SETTING   8'h00
`define CRD_ADDR_COUNT_REG   5'h13
`define CRD_ADDR_DATA_FIRST  5'h14
`define CRD_BLOCK_COUNT      8'h04

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CRD_CLK_PERIOD_NS    8
`define CRD_TIMER_TICK_NS    1000
`define CRD_TIMER_TICK_CYC   ((`CRD_TIMER_TICK_NS + `CRD_CLK_PERIOD_NS - 1) / `CRD_CLK_PERIOD_NS)

`endif

/* File: tb/crd_host_model.sv */
/*
  Host side of the link at byte level: start, stop, bytes and reads.
  Assumes the bench calls one task at a time, aligned to the clock.
*/
`timescale 1ns/1ps
`default_nettype none

module crd_host_model
  import crd_pkg::*;
(
  // Clock
  input  wire logic        clk_sys_in,
  // Events to the decoder
  output var crd_bus_evt_t evt_out
);
  initial evt_out = '0;

  // ----------------------------------------------------------------
  // Event tasks
  // ----------------------------------------------------------------
  // One event per cycle, launched just after the edge
  task automatic put(input logic [11:0] e);
    @(posedge clk_sys_in);
    evt_out <= crd_bus_evt_t'(e);
  endtask : put

  task automatic start();
    put(12'h800);
  endtask : start

  task automatic stop();
    put(12'h400);
  endtask : stop

  task automatic idle();
    put(12'h000);
  endtask : idle

  task automatic wr(input logic [7:0] b);
    put({3'h1, b, 1'b0});
  endtask : wr

  task automatic rd();
    put(12'h001);
  endtask : rd

  task automatic cmd(input logic [7:0] b);
    wr({1'b1, b[6:0]});
  endtask : cmd

  // Reserved codes are never sent; specials go as a send byte only
  task automatic special(input logic [4:0] code);
    if (code == 5'h00 || code[3:2] == 2'h3) return;
    start();
    cmd({3'h3, code});
    stop();
  endtask : special

  // Fixed four-register read; the count comes from the device
  task automatic d3_read(input int n);
    start();
    cmd(8'hD3);
    start();
    repeat (n) rd();
    stop();
  endtask : d3_read

endmodule : crd_host_model

`default_nettype wire

/* File: tb/tb_command_register_decoder.sv */
/*
  Bench of the command byte decoder: table of plain frames, then specials,
  manual timer, stray bytes, the fixed block read and a mid-run reset.
  Assumes the host model drives all bus events.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_command_register_decoder
  import crd_pkg::*;
();
  typedef struct packed {
    logic [7:0] cmd;
    logic       smb;
    logic [2:0] nwr;
    logic [2:0] nrd;
    logic [2:0] nw;
  } crd_row_t;

  logic         clk_sys_in = 1'b0;
  logic         rst_n_in   = 1'b0;
  logic         smb        = 1'b0;
  logic [7:0]   setting    = 8'h00;
  crd_bus_evt_t evt;
  logic [7:0]   rdata, wdata, rd_data, ptr, cnt;
  logic [4:0]   addr, prev_addr;
  logic         wr, rd_v, clr, m_go, m_end, m_busy;
  logic [15:0]  m_tim;
  logic [12:0]  wq[$];
  logic [7:0]   rq[$];
  int           n_clr, n_go, n_end;
  int           err_count = 0;
  int           tests_run = 0;
  // Byte, word, block SMBus (count byte skipped), block I2C, byte
  crd_row_t rows [5] = '{'{8'h81, 1'b0, 3'h1, 3'h1, 3'h1},
                         '{8'hA4, 1'b1, 3'h2, 3'h2, 3'h2},
                         '{8'hC5, 1'b1, 3'h4, 3'h3, 3'h3},
                         '{8'hC6, 1'b0, 3'h4, 3'h4, 3'h4},
                         '{8'h9F, 1'b1, 3'h1, 3'h1, 3'h1}};

  always #4 clk_sys_in = ~clk_sys_in;

  function automatic logic [7:0] rf(input logic [4:0] a);
    // Every data bit moves with the address, so no read bit is stuck
    return {a, a[4:2]} ^ 8'h3C;
  endfunction : rf

  assign rdata = rf(addr);

  crd_host_model host (.clk_sys_in(clk_sys_in), .evt_out(evt));

  crd_decoder #(.TICK_CYC(2)) dut (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .bus_evt_in(evt),
    .smbus_mode_in(smb), .integration_length_setting_in(setting),
    .reg_rdata_in(rdata), .reg_addr_out(addr), .reg_wr_out(wr),
    .reg_wdata_out(wdata), .rd_data_out(rd_data), .rd_valid_out(rd_v),
    .command_pointer_out(ptr), .xfer_count_out(cnt), .int_clear_out(clr),
    .manual_start_out(m_go), .manual_stop_out(m_end),
    .manual_busy_out(m_busy), .manual_timer_out(m_tim));

  // ----------------------------------------------------------------
  // Monitor
  // ----------------------------------------------------------------
  // A write lands at the address that stood one cycle before the pulse
  always @(posedge clk_sys_in) begin
    prev_addr <= addr;
    if (wr === 1'b1) wq.push_back({prev_addr, wdata});
    if (rd_v === 1'b1) rq.push_back(rd_data);
    if (clr === 1'b1) n_clr++;
    if (m_go === 1'b1) n_go++;
    if (m_end === 1'b1) n_end++;
  end

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic settle();
    host.idle();
    repeat (3) @(posedge clk_sys_in);
  endtask : settle

  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (5000) @(posedge clk_sys_in);
    err_count++;
    close_out();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    crd_row_t    r;
    int          skip;
    logic [4:0]  codes [3];
    codes = '{5'h01, 5'h03, 5'h02};
    repeat (20) @(posedge clk_sys_in);
    chk("ptr_rst", 16'h0000, 16'(ptr));
    chk("outs_rst", 16'h0000, 16'({wr, rd_v, clr, m_go, m_end, cnt}));
    rst_n_in <= 1'b1;
    foreach (rows[i]) begin
      r = rows[i];
      smb <= r.smb;
      wq.delete();
      rq.delete();
      skip = (r.smb && r.cmd[6:5] == 2'h2) ? 1 : 0;
      host.start();
      host.cmd(r.cmd);
      for (int k = 0; k < r.nwr; k++) host.wr(8'h30 + 8'(k));
      host.stop();
      settle();
      chk("ptr", 16'(r.cmd), 16'(ptr));
      chk("cnt", 16'(r.nw), 16'(cnt));
      chk("n_wr", 16'(r.nw), 16'(wq.size()));
      for (int k = 0; k < r.nw; k++) begin
        chk("wr", {r.cmd[4:0] + 5'(k), 8'h30 + 8'(k + skip)}, wq[k]);
      end
      host.start();
      repeat (r.nrd) host.rd();
      host.stop();
      settle();
      for (int k = 0; k < r.nrd; k++) begin
        chk("rd", 16'(rf(r.cmd[4:0] + 5'(k))), 16'(rq[k]));
      end
    end
    foreach (codes[i]) begin
      // Counters cleared before the frame, so its own pulses are kept
      n_clr = 0;
      n_go = 0;
      n_end = 0;
      host.special(codes[i]);
      settle();
      chk("clr", 16'(codes[i] == 5'h01), 16'(n_clr));
      chk("go", 16'(codes[i] == 5'h03), 16'(n_go));
      chk("end", 16'(codes[i] == 5'h02), 16'(n_end));
      chk("busy_run", 16'(codes[i] == 5'h03), 16'(m_busy));
      if (codes[i] == 5'h03) repeat (40) @(posedge clk_sys_in);
    end
    chk("busy", 16'h0000, 16'(m_busy));
    chk("timer", 16'h0001, 16'(m_tim >= 16'd21 && m_tim <= 16'd25));
    setting <= 8'hFF;
    n_go = 0;
    n_end = 0;
    host.special(5'h03);
    host.special(5'h02);
    settle();
    chk("refused", 16'h0000, 16'(n_go + n_end + m_busy));
    rq.delete();
    wq.delete();
    host.start();
    host.rd();
    host.wr(8'h12);
    host.stop();
    host.wr(8'h55);
    settle();
    chk("rd_keep", 16'(rf(5'h1F)), 16'(rq[0]));
    chk("n_wr2", 16'h0001, 16'(wq.size()));
    chk("wr_data", {5'h1F, 8'h12}, 16'(wq[0]));
    smb <= 1'b1;
    rq.delete();
    host.d3_read(5);
    settle();
    chk("blk_cnt", 16'h0004, 16'(rq[0]));
    for (int k = 0; k < 4; k++) chk("blk", 16'(rf(5'h14 + 5'(k))), 16'(rq[k + 1]));
    // Reset in mid-run: pointer back to zero, reads resume at 00h
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    chk("ptr_rst2", 16'h0000, 16'(ptr));
    chk("outs_rst2", 16'h0000, 16'({wr, rd_v, clr, m_go, m_end, cnt}));
    rst_n_in <= 1'b1;
    rq.delete();
    host.start();
    host.rd();
    host.stop();
    settle();
    chk("rd_rst", 16'(rf(5'h00)), 16'(rq[0]));
    close_out();
  end

endmodule : tb_command_register_decoder

`default_nettype wire
